// >>> include/uft_cfg.svh
`ifndef UFT_CFG_SVH
`define UFT_CFG_SVH

// Register byte offsets, one aligned 32-bit word each
`define UFT_ADDR_W 6
`define UFT_OFF_HOLD 6'h00
`define UFT_OFF_IEN 6'h04
`define UFT_OFF_ISTAT 6'h08
`define UFT_OFF_LCTL 6'h0c
`define UFT_OFF_MCTL 6'h10
`define UFT_OFF_LSTAT 6'h14
`define UFT_OFF_EFEAT 6'h18
`define UFT_OFF_FRAC 6'h1c

// Field positions
`define UFT_FCTL_FIFO_EN 0
`define UFT_FCTL_RX_FLUSH 1
`define UFT_FCTL_TX_FLUSH 2
`define UFT_IEN_RX 0
`define UFT_IEN_TX 1
`define UFT_IEN_LINE 2
`define UFT_IEN_RTS 6
`define UFT_IEN_CTS 7
`define UFT_EFEAT_ENH 4
`define UFT_EFEAT_ARTS 6
`define UFT_EFEAT_ACTS 7
`define UFT_MCTL_RTS 1
`define UFT_LCTL_STOP2 2
`define UFT_LCTL_PAR_EN 3
`define UFT_LCTL_PAR_EVEN 4

// Reset values and interrupt status codes
`define UFT_RST_REG 8'h00
`define UFT_ISTAT_NONE 8'h01
`define UFT_ISTAT_LINE 8'h06
`define UFT_ISTAT_TMO 8'h0c
`define UFT_ISTAT_RX 8'h04
`define UFT_ISTAT_TX 8'h02
`define UFT_ISTAT_FLOW 8'h20

// Timing and depth
`define UFT_FIFO_DEPTH 5'h10
`define UFT_OS16 5'h10
`define UFT_OS8 5'h08
`define UFT_OS4 5'h04
`define UFT_TMO_CHARS 6'h04
`define UFT_TMO_EXTRA 6'h0c
`define UFT_MIN_WORD 6'h05

// Trigger table: selected level, hysteresis high and low marks
`define UFT_TRIG0 5'h01
`define UFT_TRIG1 5'h04
`define UFT_TRIG2 5'h08
`define UFT_TRIG3 5'h0e
`define UFT_RTS_LO0 5'h00

`endif

// >>> include/uft_pkg.sv
package uft_pkg;
    `include "uft_cfg.svh"

    typedef enum logic [2:0] {
        TX_IDLE = 3'b000,
        TX_START = 3'b001,
        TX_DATA = 3'b010,
        TX_PAR = 3'b011,
        TX_STOP = 3'b100
    } uft_tx_state_e;

    typedef enum logic [2:0] {
        RX_IDLE = 3'b000,
        RX_START = 3'b001,
        RX_DATA = 3'b010,
        RX_PAR = 3'b011,
        RX_STOP = 3'b100
    } uft_rx_state_e;

    typedef struct packed {
        logic read;
        logic write;
        logic [`UFT_ADDR_W-1:0] address;
        logic [31:0] writedata;
    } uft_bus_req_s;

    typedef struct packed {
        logic brk;
        logic frame;
        logic par;
        logic [7:0] data;
    } uft_rx_entry_s;
endpackage : uft_pkg

// >>> src/uft_core.sv
// Summary of operation
// - Each transmitted bit lasts 16, 8 or 4 oversampling clocks.
// - Frame: start, data LSB first, optional parity, one or two stops.
// - With FIFO enabled, holding writes push into a 16-entry FIFO; a write while it is full is dropped.
// - Without FIFO, holding-empty sets when the byte moves to the shifter.
// - Holding-empty raises transmit interrupt, status bit 1, if enable bit 1.
// - FIFO mode: holding-empty means FIFO empty; interrupt below trigger level.
// - Transmitter-empty sets only when shifter and FIFO are both empty.
// - Start edge: wait half a bit, accept start only if still low.
// - Every later bit is sampled at its centre by the same counter.
// - Receive FIFO holds 16 entries of data plus three error tags.
// - Reading receive data pops FIFO; status bits 2-4 show new head.
// - Enable bit 0 gives receive interrupt per character or at trigger.
// - Time-out interrupt after four word lengths plus twelve bit idle.
// - Auto request enabled by feature bit 6, started by modem bit 1.
// - Request rising raises flow interrupt, status bit 5, if enable bit 6.
// - Request goes high when fill reaches next trigger level above; at trigger setting 11 it is level 14 itself.
// - Request goes low when fill falls to trigger level below; at trigger setting 00 that mark is zero.
// - Receiver keeps storing characters until the FIFO is full.
// - Feature bit 7 lets clear-to-send pause and restart the transmitter.
// - Clear-to-send rising raises flow interrupt, status bit 5, if bit 7.
// - Transmitter pauses after the current stop bit, resumes when low.
// - Oversample field: 00 is 16X, 01 is 8X, 10 is 4X.
//
// Register access over Avalon-MM and the address map were decided locally.
`include "uft_cfg.svh"

module uft_core (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Avalon-MM slave
    input wire uft_pkg::uft_bus_req_s bus_req,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Serial line and flow control
    input wire logic rx_in,
    output logic tx_out,
    input wire logic cts_n,
    output logic rts_n,
    // Interrupt
    output logic irq
);
    import uft_pkg::*;

    function automatic logic [4:0] bit_len(input logic [1:0] sel);
        case (sel)
            2'b01: bit_len = `UFT_OS8;
            2'b10: bit_len = `UFT_OS4;
            default: bit_len = `UFT_OS16;
        endcase
    endfunction : bit_len

    function automatic logic [4:0] trig_lvl(input logic [1:0] sel);
        case (sel)
            2'b00: trig_lvl = `UFT_TRIG0;
            2'b01: trig_lvl = `UFT_TRIG1;
            2'b10: trig_lvl = `UFT_TRIG2;
            default: trig_lvl = `UFT_TRIG3;
        endcase
    endfunction : trig_lvl

    // Hysteresis marks are the neighbours in the trigger table
    function automatic logic [4:0] rts_hi(input logic [1:0] sel);
        rts_hi = (sel == 2'b11) ? `UFT_TRIG3 : trig_lvl(sel + 2'b01);
    endfunction : rts_hi

    function automatic logic [4:0] rts_lo(input logic [1:0] sel);
        rts_lo = (sel == 2'b00) ? `UFT_RTS_LO0 : trig_lvl(sel - 2'b01);
    endfunction : rts_lo

    function automatic logic par_bit(input logic [7:0] d, input logic [1:0] wl,
                                     input logic even);
        par_bit = (^(d & (8'hff >> (2'h3 - wl)))) ^ ~even;
    endfunction : par_bit

    logic [7:0] ien, fctl, lctl, mctl, efeat, frac, istat, istat_seen, rd_val;
    logic overrun, thr_ack, flow_int, tmo_flag, rts_prev, cts_prev, rx_prev;
    logic acc_wr, acc_rd, hold_wr, hold_rd, istat_rd, lstat_rd, fctl_wr;
    logic fifo_en, tx_flush, rx_flush, tx_push, tx_pop, tx_empty, tx_full;
    logic rx_push, rx_pop, rx_empty, rx_full, rx_full_eff, tx_full_eff;
    logic [7:0] tx_head;
    logic [4:0] tx_count, rx_count, bl, tx_cnt, rx_cnt;
    uft_rx_entry_s rx_head, rx_new;
    logic line_int, rx_int, tmo_int, thr_cond, thr_int, tx_tick, rx_tick;
    logic [2:0] tx_idx, rx_idx;
    logic [7:0] transmit_shift_reg, receive_shift_reg;
    logic tx_stop2, rx_par_err;
    logic [9:0] tmo_cnt, tmo_limit;
    uft_tx_state_e tx_state;
    uft_rx_state_e rx_state;

    // Bus handshake: one wait cycle, then the access takes effect
    assign acc_wr = bus_req.write & ~waitrequest;
    assign acc_rd = bus_req.read & ~waitrequest;
    assign hold_wr = acc_wr && (bus_req.address == `UFT_OFF_HOLD);
    assign hold_rd = acc_rd && (bus_req.address == `UFT_OFF_HOLD);
    assign istat_rd = acc_rd && (bus_req.address == `UFT_OFF_ISTAT);
    assign lstat_rd = acc_rd && (bus_req.address == `UFT_OFF_LSTAT);
    assign fctl_wr = acc_wr && (bus_req.address == `UFT_OFF_ISTAT);

    assign fifo_en = fctl[`UFT_FCTL_FIFO_EN];
    // Changing FIFO mode drops stale data in both directions
    assign tx_flush = fctl_wr && (bus_req.writedata[`UFT_FCTL_TX_FLUSH]
                      || bus_req.writedata[`UFT_FCTL_FIFO_EN] != fifo_en);
    assign rx_flush = fctl_wr && (bus_req.writedata[`UFT_FCTL_RX_FLUSH]
                      || bus_req.writedata[`UFT_FCTL_FIFO_EN] != fifo_en);
    assign bl = bit_len(frac[5:4]);

    // Without FIFO the holding stage is one deep
    assign tx_full_eff = fifo_en ? tx_full : ~tx_empty;
    assign rx_full_eff = fifo_en ? rx_full : ~rx_empty;
    assign tx_push = hold_wr & ~tx_full_eff;
    assign rx_pop = hold_rd & ~rx_empty;

    uft_fifo #(.W(8)) u_tx_fifo (
        .clk(clk),
        .rst(rst),
        .flush(tx_flush),
        .push(tx_push),
        .wdata(bus_req.writedata[7:0]),
        .pop(tx_pop),
        .rdata(tx_head),
        .count(tx_count),
        .empty(tx_empty),
        .full(tx_full)
    );

    uft_fifo #(.W(11)) u_rx_fifo (
        .clk(clk),
        .rst(rst),
        .flush(rx_flush),
        .push(rx_push & ~rx_full_eff),
        .wdata(rx_new),
        .pop(rx_pop),
        .rdata(rx_head),
        .count(rx_count),
        .empty(rx_empty),
        .full(rx_full)
    );

    // Interrupt sources and status code, highest priority first
    assign line_int = ien[`UFT_IEN_LINE]
        & (overrun | (~rx_empty & (rx_head.brk | rx_head.frame | rx_head.par)));
    assign rx_int = ien[`UFT_IEN_RX] & ~rx_empty
        & (~fifo_en | (rx_count >= trig_lvl(fctl[7:6])));
    assign tmo_int = ien[`UFT_IEN_RX] & tmo_flag;
    assign thr_cond = fifo_en ? (tx_count < trig_lvl(fctl[5:4])) : tx_empty;
    assign thr_int = ien[`UFT_IEN_TX] & thr_cond & ~thr_ack;

    always_comb begin
        if (line_int) begin
            istat = `UFT_ISTAT_LINE;
        end else if (tmo_int) begin
            istat = `UFT_ISTAT_TMO;
        end else if (rx_int) begin
            istat = `UFT_ISTAT_RX;
        end else if (thr_int) begin
            istat = `UFT_ISTAT_TX;
        end else if (flow_int) begin
            istat = `UFT_ISTAT_FLOW;
        end else begin
            istat = `UFT_ISTAT_NONE;
        end
        istat[7:6] = {fifo_en, fifo_en};
    end

    always_comb begin
        if (bus_req.address == `UFT_OFF_HOLD) begin
            rd_val = rx_empty ? 8'h00 : rx_head.data;
        end else if (bus_req.address == `UFT_OFF_IEN) begin
            rd_val = ien;
        end else if (bus_req.address == `UFT_OFF_ISTAT) begin
            rd_val = istat;
        end else if (bus_req.address == `UFT_OFF_LCTL) begin
            rd_val = lctl;
        end else if (bus_req.address == `UFT_OFF_MCTL) begin
            rd_val = mctl;
        end else if (bus_req.address == `UFT_OFF_LSTAT) begin
            rd_val = {1'b0, tx_empty & (tx_state == TX_IDLE), tx_empty,
                      ~rx_empty & rx_head.brk, ~rx_empty & rx_head.frame,
                      ~rx_empty & rx_head.par, overrun, ~rx_empty};
        end else if (bus_req.address == `UFT_OFF_EFEAT) begin
            rd_val = efeat;
        end else if (bus_req.address == `UFT_OFF_FRAC) begin
            rd_val = frac;
        end else begin
            rd_val = 8'h00;
        end
    end

    // Read data is captured in the wait cycle and stands while waitrequest is low
    always_ff @(posedge clk) begin
        if (rst) begin
            waitrequest <= 1'b1;
            readdata <= 32'h0;
            istat_seen <= `UFT_ISTAT_NONE;
        end else if ((bus_req.read || bus_req.write) && waitrequest) begin
            waitrequest <= 1'b0;
            readdata <= {24'h0, bus_req.read ? rd_val : 8'h00};
            istat_seen <= istat;
        end else begin
            waitrequest <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ien <= `UFT_RST_REG;
            fctl <= `UFT_RST_REG;
            lctl <= `UFT_RST_REG;
            mctl <= `UFT_RST_REG;
            efeat <= `UFT_RST_REG;
            frac <= `UFT_RST_REG;
        end else if (acc_wr) begin
            if (bus_req.address == `UFT_OFF_IEN) begin
                // Flow interrupt enables only stick once enhanced mode is on
                ien <= {bus_req.writedata[7:6] & {2{efeat[`UFT_EFEAT_ENH]}},
                        3'h0, bus_req.writedata[2:0]};
            end else if (bus_req.address == `UFT_OFF_ISTAT) begin
                fctl <= {bus_req.writedata[7:4], 3'h0, bus_req.writedata[0]};
            end else if (bus_req.address == `UFT_OFF_LCTL) begin
                lctl <= bus_req.writedata[7:0];
            end else if (bus_req.address == `UFT_OFF_MCTL) begin
                mctl <= bus_req.writedata[7:0];
            end else if (bus_req.address == `UFT_OFF_EFEAT) begin
                efeat <= bus_req.writedata[7:0];
            end else if (bus_req.address == `UFT_OFF_FRAC) begin
                frac <= bus_req.writedata[7:0];
            end
        end
    end

    // Sticky flags: a set in the same cycle as its clear wins
    always_ff @(posedge clk) begin
        if (rst) begin
            overrun <= 1'b0;
            thr_ack <= 1'b0;
            flow_int <= 1'b0;
        end else begin
            if (rx_push && rx_full_eff) begin
                overrun <= 1'b1;
            end else if (lstat_rd) begin
                overrun <= 1'b0;
            end
            if (istat_rd && istat_seen[5:0] == 6'(`UFT_ISTAT_TX)) begin
                thr_ack <= 1'b1;
            end else if (hold_wr || !thr_cond) begin
                thr_ack <= 1'b0;
            end
            if ((rts_n && !rts_prev && ien[`UFT_IEN_RTS])
                || (cts_n && !cts_prev && ien[`UFT_IEN_CTS])) begin
                flow_int <= 1'b1;
            end else if (istat_rd && istat_seen[5]) begin
                flow_int <= 1'b0;
            end
        end
    end

    // Idle limit in oversample clocks: four words plus twelve bits
    // Widen before the product: six bits would wrap at 16X
    assign tmo_limit = 10'(bl) * ((10'(`UFT_MIN_WORD) + 10'(lctl[1:0])) * 10'(`UFT_TMO_CHARS)
                                  + 10'(`UFT_TMO_EXTRA));

    always_ff @(posedge clk) begin
        if (rst) begin
            tmo_cnt <= 10'h000;
            tmo_flag <= 1'b0;
        end else if (rx_empty || rx_push || rx_pop) begin
            tmo_cnt <= 10'h000;
            tmo_flag <= 1'b0;
        end else if (tmo_cnt == tmo_limit - 10'h001) begin
            tmo_flag <= 1'b1;
        end else begin
            tmo_cnt <= tmo_cnt + 10'h001;
        end
    end

    // Transmitter; a new frame only starts from idle, so a pause lands after a stop bit
    assign tx_tick = (tx_cnt == bl - 5'h01);
    assign tx_pop = (tx_state == TX_IDLE) & ~tx_empty
                    & ~(efeat[`UFT_EFEAT_ACTS] & cts_n);

    always_ff @(posedge clk) begin
        if (rst) begin
            tx_state <= TX_IDLE;
            tx_out <= 1'b1;
            tx_cnt <= 5'h00;
            tx_idx <= 3'h0;
            transmit_shift_reg <= 8'h00;
            tx_stop2 <= 1'b0;
        end else begin
            tx_cnt <= (tx_state == TX_IDLE || tx_tick) ? 5'h00 : tx_cnt + 5'h01;
            case (tx_state)
                TX_IDLE: begin
                    if (tx_pop) begin
                        transmit_shift_reg <= tx_head;
                        tx_out <= 1'b0;
                        tx_stop2 <= 1'b0;
                        tx_state <= TX_START;
                    end
                end
                TX_START: begin
                    if (tx_tick) begin
                        tx_idx <= 3'h0;
                        tx_out <= transmit_shift_reg[0];
                        tx_state <= TX_DATA;
                    end
                end
                TX_DATA: begin
                    if (tx_tick && tx_idx == 3'(4 + lctl[1:0])) begin
                        if (lctl[`UFT_LCTL_PAR_EN]) begin
                            tx_out <= par_bit(transmit_shift_reg, lctl[1:0], lctl[`UFT_LCTL_PAR_EVEN]);
                            tx_state <= TX_PAR;
                        end else begin
                            tx_out <= 1'b1;
                            tx_state <= TX_STOP;
                        end
                    end else if (tx_tick) begin
                        tx_idx <= tx_idx + 3'h1;
                        tx_out <= transmit_shift_reg[tx_idx + 3'h1];
                    end
                end
                TX_PAR: begin
                    if (tx_tick) begin
                        tx_out <= 1'b1;
                        tx_state <= TX_STOP;
                    end
                end
                default: begin
                    if (tx_tick && lctl[`UFT_LCTL_STOP2] && !tx_stop2) begin
                        tx_stop2 <= 1'b1;
                    end else if (tx_tick) begin
                        tx_state <= TX_IDLE;
                    end
                end
            endcase
        end
    end

    // Receiver; every sample is taken mid-bit
    assign rx_tick = (rx_cnt == bl - 5'h01);
    assign rx_push = (rx_state == RX_STOP) & rx_tick;
    assign rx_new = '{brk: ~rx_in & (receive_shift_reg == 8'h00), frame: ~rx_in,
                      par: rx_par_err & lctl[`UFT_LCTL_PAR_EN], data: receive_shift_reg};

    always_ff @(posedge clk) begin
        if (rst) begin
            rx_state <= RX_IDLE;
            rx_prev <= 1'b1;
            rx_cnt <= 5'h00;
            rx_idx <= 3'h0;
            receive_shift_reg <= 8'h00;
            rx_par_err <= 1'b0;
        end else begin
            rx_prev <= rx_in;
            rx_cnt <= (rx_state == RX_IDLE || rx_tick) ? 5'h00 : rx_cnt + 5'h01;
            case (rx_state)
                RX_IDLE: begin
                    if (rx_prev && !rx_in) begin
                        rx_state <= RX_START;
                    end
                end
                RX_START: begin
                    if (rx_cnt == (bl >> 1) - 5'h01) begin
                        rx_cnt <= 5'h00;
                        rx_idx <= 3'h0;
                        receive_shift_reg <= 8'h00;
                        rx_par_err <= 1'b0;
                        rx_state <= rx_in ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (rx_tick) begin
                        receive_shift_reg[rx_idx] <= rx_in;
                        rx_idx <= rx_idx + 3'h1;
                        if (rx_idx == 3'(4 + lctl[1:0])) begin
                            rx_state <= lctl[`UFT_LCTL_PAR_EN] ? RX_PAR : RX_STOP;
                        end
                    end
                end
                RX_PAR: begin
                    if (rx_tick) begin
                        rx_par_err <= rx_in
                            != par_bit(receive_shift_reg, lctl[1:0], lctl[`UFT_LCTL_PAR_EVEN]);
                        rx_state <= RX_STOP;
                    end
                end
                default: begin
                    if (rx_tick) begin
                        rx_state <= RX_IDLE;
                    end
                end
            endcase
        end
    end

    // Request-to-send with hysteresis between the two neighbouring levels
    always_ff @(posedge clk) begin
        if (rst) begin
            rts_n <= 1'b1;
            rts_prev <= 1'b1;
            cts_prev <= 1'b1;
            irq <= 1'b0;
        end else begin
            rts_prev <= rts_n;
            cts_prev <= cts_n;
            irq <= (istat[5:0] != 6'(`UFT_ISTAT_NONE));
            if (!efeat[`UFT_EFEAT_ARTS] || !mctl[`UFT_MCTL_RTS]) begin
                rts_n <= ~mctl[`UFT_MCTL_RTS];
            end else if (rx_count >= rts_hi(fctl[7:6])) begin
                rts_n <= 1'b1;
            end else if (rx_count <= rts_lo(fctl[7:6])) begin
                rts_n <= 1'b0;
            end
        end
    end
endmodule : uft_core

// >>> src/uft_fifo.sv
`include "uft_cfg.svh"

module uft_fifo #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic flush,
    // Write side
    input wire logic push,
    input wire logic [W-1:0] wdata,
    // Read side
    input wire logic pop,
    output logic [W-1:0] rdata,
    // Fill state
    output logic [4:0] count,
    output logic empty,
    output logic full
);
    logic [W-1:0] mem [0:15];
    logic [3:0] wptr;
    logic [3:0] rptr;
    logic do_push;
    logic do_pop;

    assign do_push = push & ~full;
    assign do_pop = pop & ~empty;
    assign empty = (count == 5'h00);
    assign full = (count == `UFT_FIFO_DEPTH);
    assign rdata = mem[rptr];

    always_ff @(posedge clk) begin
        if (do_push) begin
            mem[wptr] <= wdata;
        end
    end

    // Pointers wrap naturally at sixteen entries
    always_ff @(posedge clk) begin
        if (rst || flush) begin
            wptr <= 4'h0;
            rptr <= 4'h0;
            count <= 5'h00;
        end else begin
            if (do_push) begin
                wptr <= wptr + 4'h1;
            end
            if (do_pop) begin
                rptr <= rptr + 4'h1;
            end
            if (do_push && !do_pop) begin
                count <= count + 5'h01;
            end else if (do_pop && !do_push) begin
                count <= count - 5'h01;
            end
        end
    end
endmodule : uft_fifo

// >>> test/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import uft_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    uft_bus_req_s req = '0;
    logic [31:0] readdata, q;
    logic waitrequest, rx_in, tx_out, cts_n, rts_n, irq, e;
    logic [7:0] b[$];
    int errors = 0;
    int num_checks = 0;
    always #20 clk = ~clk;
    uft_core i_dut (.clk(clk), .rst(rst), .bus_req(req), .readdata(readdata),
        .waitrequest(waitrequest), .rx_in(rx_in), .tx_out(tx_out), .cts_n(cts_n),
        .rts_n(rts_n), .irq(irq));
    uft_remote #(.L(4)) i_rem (.clk(clk), .tx_out(tx_out), .rx_in(rx_in), .cts_n(cts_n));
    // Extra idle edges let registered outputs settle before the next look
    task automatic acc(input logic wr, input logic [5:0] a, input logic [7:0] d);
        req <= '{read: ~wr, write: wr, address: a, writedata: {24'h0, d}};
        @(posedge clk iff waitrequest === 1'b0);
        q = readdata;
        req <= '0;
        repeat (3) @(posedge clk);
    endtask : acc
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        num_checks++;
        if (g !== x) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, x, g);
        end
    endtask : chk
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish
    function automatic logic rts_exp(input int fill, input logic prev);
        return (fill >= 4) ? 1'b1 : ((fill <= 0) ? 1'b0 : prev);
    endfunction : rts_exp
    initial begin
        void'($urandom(32'h2904));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        acc(0, 6'h14, 0);
        chk("line_status", 32'h60, q);
        acc(0, 6'h20, 0);
        chk("unmapped", 32'h0, q);
        acc(1, 6'h08, 8'h01);
        acc(1, 6'h0c, 8'h03);
        acc(1, 6'h1c, 8'h20);
        acc(1, 6'h04, 8'h01);
        repeat (3) begin
            b.push_back(8'($urandom));
            acc(1, 6'h00, b[$]);
        end
        acc(0, 6'h14, 0);
        chk("busy_status", 32'h0, q[6:5]);
        repeat (150) @(posedge clk);
        foreach (b[i]) chk("tx_byte", b[i], i_rem.got[i]);
        acc(0, 6'h14, 0);
        chk("idle_status", 32'h60, q);
        b = {8'($urandom) | 8'h01, 8'($urandom)};
        i_rem.send(b[0], 1'b0);
        i_rem.send(b[1], 1'b1);
        chk("rx_irq", 1'b1, irq);
        acc(0, 6'h14, 0);
        chk("err_tags", 32'h9, q[4:0]);
        acc(0, 6'h00, 0);
        chk("rx_byte0", b[0], q);
        acc(0, 6'h14, 0);
        chk("tags_next", 32'h1, q[4:0]);
        acc(0, 6'h00, 0);
        chk("rx_byte1", b[1], q);
        acc(1, 6'h18, 8'h40);
        acc(1, 6'h10, 8'h02);
        chk("rts_start", 1'b0, rts_n);
        e = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (i < 4) begin
                i_rem.send(8'($urandom), 1'b1);
            end else begin
                acc(0, 6'h00, 0);
            end
            e = rts_exp((i < 4) ? i + 1 : 7 - i, e);
            chk("rts_flow", e, rts_n);
        end
        b = {8'($urandom)};
        i_rem.send(b[0], 1'b1);
        acc(0, 6'h08, 0);
        chk("rx_int_code", 32'hc4, q);
        repeat (180) @(posedge clk);
        acc(0, 6'h08, 0);
        chk("tmo_code", 32'hcc, q);
        acc(0, 6'h00, 0);
        chk("tmo_byte", b[0], q);
        acc(1, 6'h18, 8'h00);
        chk("rts_follow", 1'b0, rts_n);
        acc(1, 6'h10, 8'h00);
        chk("rts_manual", 1'b1, rts_n);
        acc(1, 6'h18, 8'h80);
        i_rem.cts_q <= 1'b1;
        b = {8'($urandom)};
        acc(1, 6'h00, b[0]);
        repeat (80) @(posedge clk);
        chk("cts_hold", 32'h3, 32'(i_rem.got.size()));
        i_rem.cts_q <= 1'b0;
        repeat (80) @(posedge clk);
        chk("cts_resume", b[0], i_rem.got[3]);
        acc(1, 6'h04, 8'h02);
        chk("tx_irq", 1'b1, irq);
        acc(0, 6'h08, 0);
        chk("tx_int_code", 32'hc2, q);
        tally_and_finish();
    end
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        tally_and_finish();
    end
endmodule : tb_top

// >>> test/uft_core_asserts.sv
module uft_core_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register bus
    input wire uft_pkg::uft_bus_req_s bus_req,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // Serial line and flow control
    input wire logic rx_in,
    input wire logic tx_out,
    input wire logic cts_n,
    input wire logic rts_n,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    import uft_pkg::*;
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    // Shortest legal bit is four clocks, so 4X mode bounds every mode
    sequence s_bit_hold;
        $stable(tx_out) [*3];
    endsequence
    sequence s_req_idle;
        waitrequest && !bus_req.read && !bus_req.write;
    endsequence
    AST_TX_BIT_MIN: assert property ($changed(tx_out) |=> s_bit_hold)
        else $error("tx bit shorter than four clocks");
    AST_WAIT_ONE: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low longer than one cycle");
    AST_WAIT_ANSWER: assert property ((bus_req.read || bus_req.write) && waitrequest |=> !waitrequest)
        else $error("access not answered after one wait cycle");
    AST_WAIT_CAUSE: assert property ($fell(waitrequest) |-> $past(bus_req.read || bus_req.write))
        else $error("answer without a request");
    AST_NO_SPURIOUS: assert property (s_req_idle |=> waitrequest)
        else $error("waitrequest dropped while bus idle");
    AST_READ_UPPER: assert property (!waitrequest |-> readdata[31:8] == 24'h0)
        else $error("readdata upper bits not zero");
    AST_READ_HOLD: assert property ($past(waitrequest) && waitrequest |-> $stable(readdata))
        else $error("readdata changed outside an access");
    AST_RESET_IDLE: assert property (disable iff (1'b0) rst |=> tx_out && rts_n && !irq)
        else $error("outputs not idle after reset");
endmodule : uft_core_chk

bind uft_core uft_core_chk i_chk (.clk(clk), .rst(rst), .bus_req(bus_req), .readdata(readdata),
    .waitrequest(waitrequest), .rx_in(rx_in), .tx_out(tx_out), .cts_n(cts_n), .rts_n(rts_n),
    .irq(irq));

// >>> test/uft_remote.sv
module uft_remote #(
    parameter int L = 4
) (
    // Clock
    input wire logic clk,
    // Serial lines
    input wire logic tx_out,
    output logic rx_in,
    output logic cts_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic rx_q = 1'b1;
    logic cts_q = 1'b0;
    logic [7:0] got[$];
    logic [7:0] sh;
    assign rx_in = rx_q;
    assign cts_n = cts_q;
    task automatic send(input logic [7:0] d, input logic stp);
        logic [9:0] f;
        f = {stp, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rx_q <= f[i];
            repeat (L) @(posedge clk);
        end
        rx_q <= 1'b1;
        repeat (L) @(posedge clk);
    endtask : send
    initial forever begin
        @(negedge tx_out);
        repeat (L / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (L) @(posedge clk);
            sh[i] = tx_out;
        end
        repeat (L) @(posedge clk);
        got.push_back(sh);
    end
endmodule : uft_remote
